// [shared/timer8_pwm_defs.svh]
// register offsets, field positions, reset values and prescaler masks of the 8-bit pwm timer
`ifndef TIMER8_PWM_DEFS_SVH
`define TIMER8_PWM_DEFS_SVH

`define T8_OFS_CTRL     8'h00
`define T8_OFS_COUNT    8'h04
`define T8_OFS_CMP_A    8'h08
`define T8_OFS_CMP_B    8'h0C
`define T8_OFS_FLAGS    8'h10
`define T8_OFS_STATE    8'h14

`define T8_F_WAVE_SEL   0
`define T8_F_ACTION     4
`define T8_F_CLK_SEL    8
`define T8_F_ASYNC      11
`define T8_F_PIN_DIR    12
`define T8_F_PORT_VAL   14

`define T8_CTRL_RST     16'h0000
`define T8_CTRL_WMASK   16'hFFF7
`define T8_COUNT_RST    8'h00
`define T8_CMP_RST      8'h00
`define T8_TOP_MAX      8'hFF
`define T8_BOTTOM       8'h00

`define T8_WAVE_PC_FF   3'h1
`define T8_WAVE_FAST_FF 3'h3
`define T8_WAVE_PC_A    3'h5
`define T8_WAVE_FAST_A  3'h7

`define T8_ACT_OFF      2'h0
`define T8_ACT_TOGGLE   2'h1
`define T8_ACT_NONINV   2'h2

`define T8_F_OVF        0
`define T8_F_CMPF       1

`define T8_DIV_1        10'h000
`define T8_DIV_8        10'h007
`define T8_DIV_32       10'h01F
`define T8_DIV_64       10'h03F
`define T8_DIV_128      10'h07F
`define T8_DIV_256      10'h0FF
`define T8_DIV_1024     10'h3FF

`endif

// [shared/timer8_pwm_pkg.sv]
// types shared by the 8-bit pwm timer
package timer8_pwm_pkg;
   typedef enum logic {DIR_UP, DIR_DOWN} dir_e;
   typedef logic [7:0] count_t;
   typedef logic [1:0] action_t;
endpackage : timer8_pwm_pkg

// [verification/pwm_load_model.sv]
// load on the waveform pins: resolves each pin level and tallies high cycles and rising edges of pin 0 only
`timescale 1ns/1ps
module pwm_load_model (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [1:0]  pin_out_i,
   input  wire logic [1:0]  pin_oe_i,
   output      logic [1:0]  level_o,
   output      logic [31:0] high_cnt_o,
   output      logic [31:0] rise_cnt_o
);
   logic prev;
   // undriven pin reads low
   // the load has a pull-down, so a pin whose driver is off never shows the last value
   assign level_o = pin_oe_i & pin_out_i;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         high_cnt_o <= 32'h0000_0000;
         rise_cnt_o <= 32'h0000_0000;
         prev       <= 1'b0;
      end else begin
         high_cnt_o <= high_cnt_o + 32'(level_o[0]);
         rise_cnt_o <= rise_cnt_o + 32'(level_o[0] & ~prev);
         prev       <= level_o[0];
      end
   end
endmodule : pwm_load_model

// [verification/tb_timer8_pwm_waveform_modes.sv]
// self-checking bench for the pwm timer: waveform duty, toggling, prescale, pins, async ticks
`timescale 1ns/1ps
`include "timer8_pwm_defs.svh"
module tb_timer8_pwm_waveform_modes;
   import timer8_pwm_pkg::*;
   logic        clk_i, rst_i, cyc, stb, we, ext_osc;
   logic [7:0]  adr, c;
   logic [3:0]  sel;
   logic [31:0] dat_w, dat_o, q, hi, ri;
   logic        ack_o;
   count_t      counter_value_o;
   logic [1:0]  pin_out_o, pin_oe_o, level;
   logic [31:0] high_cnt, rise_cnt;
   logic [2:0]  w;
   int          failures, cmp_count, seed, per, e;

   timer8_pwm DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(sel), .dat_i(dat_w), .dat_o(dat_o), .ack_o(ack_o), .ext_osc_i(ext_osc),
      .counter_value_o(counter_value_o), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o));
   pwm_load_model load (.clk_i(clk_i), .rst_i(rst_i), .pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o),
      .level_o(level), .high_cnt_o(high_cnt), .rise_cnt_o(rise_cnt));

   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   task automatic stop_test;
      $display("compares %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : stop_test

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // one classic cycle; the wait ends on ack only, the watchdog cuts a hang
   task automatic wb(input logic wr_en, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= wr_en; adr <= a; dat_w <= d; sel <= 4'hF;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      r = dat_o;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask : wb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      wb(1'b1, a, d, r);
   endtask : wr

   function automatic logic [31:0] ctrl(input logic [2:0] ws, input logic [1:0] act, input logic [2:0] cs,
                                         input logic dir, input logic port, input logic as);
      return (32'(ws) << `T8_F_WAVE_SEL) | (32'(act) << `T8_F_ACTION) | (32'(cs) << `T8_F_CLK_SEL) |
             (32'(as) << `T8_F_ASYNC) | (32'(dir) << `T8_F_PIN_DIR) | (32'(port) << `T8_F_PORT_VAL);
   endfunction : ctrl

   // high ticks in one period: fast is set at bottom until the match, dual slope is high below the match
   function automatic int exp_high(input logic [2:0] ws, input logic [1:0] act, input logic [7:0] cv);
      int up;
      up = (ws == `T8_WAVE_FAST_FF) ? int'(cv) + 1 : 2 * int'(cv);
      if (act == 2'h3) return ((ws == `T8_WAVE_FAST_FF) ? 256 : 510) - up;
      return up;
   endfunction : exp_high

   task automatic measure(input int n, output logic [31:0] h, output logic [31:0] r);
      logic [31:0] h0, r0;
      @(posedge clk_i);
      h0 = high_cnt;
      r0 = rise_cnt;
      repeat (n) @(posedge clk_i);
      h = high_cnt - h0;
      r = rise_cnt - r0;
   endtask : measure

   initial begin
      repeat (90000) @(posedge clk_i);
      failures++;
      $display("watchdog expired");
      stop_test();
   end

   initial begin
      rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'hF;
      dat_w = 32'h0000_0000; ext_osc = 1'b0; failures = 0; cmp_count = 0; seed = 32'hebe6_1549;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 7; i++) begin
         wb(1'b0, 8'(i * 4), 32'h0, q);
         check(q, 32'h0000_0000);
      end
      $display("test reset values done");
      for (int m = 0; m < 2; m++) for (int a = 2; a < 4; a++) for (int k = 0; k < 3; k++) begin
         w = m ? `T8_WAVE_PC_FF : `T8_WAVE_FAST_FF;
         c = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($random(seed));
         per = m ? 510 : 256;
         e = exp_high(w, 2'(a), c);
         wr(`T8_OFS_CMP_A, 32'(c));
         wr(`T8_OFS_CTRL, ctrl(w, 2'(a), 3'h1, 1'b1, 1'b0, 1'b0));
         wr(`T8_OFS_FLAGS, 32'h7);
         repeat (3 * per) @(posedge clk_i);
         measure(2 * per, hi, ri);
         check(hi, 32'(2 * e));
         check(ri, (e == 0 || e == per) ? 32'h0 : 32'h2);
         wb(1'b0, `T8_OFS_FLAGS, 32'h0, q);
         check(q & 32'h3, 32'h3);
      end
      $display("test fast and dual slope duty done");
      for (int k = 0; k < 2; k++) begin
         c = k ? (8'($random(seed)) & 8'h0F) : 8'h00;
         wr(`T8_OFS_CMP_A, 32'(c));
         wr(`T8_OFS_CTRL, ctrl(`T8_WAVE_FAST_A, `T8_ACT_TOGGLE, 3'h1, 1'b1, 1'b0, 1'b0));
         repeat (1200) @(posedge clk_i);
         measure(16 * (int'(c) + 1), hi, ri);
         check(hi, 32'(8 * (int'(c) + 1)));
         check(ri, 32'h8);
      end
      $display("test toggle done");
      c = 8'($random(seed));
      wr(`T8_OFS_CMP_A, 32'(c));
      wr(`T8_OFS_CTRL, ctrl(`T8_WAVE_FAST_FF, `T8_ACT_NONINV, 3'h2, 1'b1, 1'b0, 1'b0));
      repeat (3 * 2048) @(posedge clk_i);
      measure(2048, hi, ri);
      check(hi, 32'(8 * exp_high(`T8_WAVE_FAST_FF, `T8_ACT_NONINV, c)));
      $display("test prescale done");
      wr(`T8_OFS_CTRL, ctrl(`T8_WAVE_FAST_FF, `T8_ACT_NONINV, 3'h1, 1'b0, 1'b0, 1'b0));
      repeat (4) @(posedge clk_i);
      check(32'(pin_oe_o), 32'h0);
      measure(300, hi, ri);
      check(hi, 32'h0);
      for (int p = 0; p < 2; p++) begin
         wr(`T8_OFS_CTRL, ctrl(`T8_WAVE_FAST_FF, `T8_ACT_OFF, 3'h1, 1'b1, 1'(p), 1'b0));
         repeat (4) @(posedge clk_i);
         check(32'(pin_out_o), 32'(p));
         check(32'(pin_oe_o), 32'h1);
      end
      $display("test pin control done");
      wr(`T8_OFS_CTRL, ctrl(3'h0, `T8_ACT_OFF, 3'h0, 1'b0, 1'b0, 1'b0));
      wr(`T8_OFS_FLAGS, 32'h7);
      wb(1'b0, `T8_OFS_FLAGS, 32'h0, q);
      check(q & 32'h7, 32'h0);
      wr(`T8_OFS_COUNT, 32'h0);
      wr(`T8_OFS_CTRL, ctrl(3'h0, `T8_ACT_OFF, 3'h1, 1'b0, 1'b0, 1'b1));
      repeat (40) @(posedge clk_i);
      wb(1'b0, `T8_OFS_COUNT, 32'h0, q);
      check(q, 32'h0);
      repeat (10) begin
         repeat (4) @(posedge clk_i);
         ext_osc <= 1'b1;
         repeat (4) @(posedge clk_i);
         ext_osc <= 1'b0;
      end
      repeat (10) @(posedge clk_i);
      wb(1'b0, `T8_OFS_COUNT, 32'h0, q);
      check(q, 32'hA);
      check(32'(counter_value_o), 32'hA);
      $display("test async ticks done");
      // counter written while running: the first tick after the write must not match
      wr(`T8_OFS_CTRL, ctrl(3'h0, `T8_ACT_OFF, 3'h0, 1'b0, 1'b0, 1'b0));
      wr(`T8_OFS_CMP_A, 32'h5);
      for (int k = 0; k < 2; k++) begin
         wr(`T8_OFS_FLAGS, 32'h7);
         wr(`T8_OFS_CTRL, ctrl(3'h0, `T8_ACT_OFF, 3'h1, 1'b0, 1'b0, 1'b0));
         wr(`T8_OFS_COUNT, 32'(5 - k));
         wr(`T8_OFS_CTRL, ctrl(3'h0, `T8_ACT_OFF, 3'h0, 1'b0, 1'b0, 1'b0));
         wb(1'b0, `T8_OFS_FLAGS, 32'h0, q);
         check(q & 32'h2, k ? 32'h2 : 32'h0);
      end
      $display("test counter write blocking done");
      stop_test();
   end
endmodule : tb_timer8_pwm_waveform_modes

// [verilog/timer8_pwm.sv]
// 8-bit timer with fast and phase correct pwm, two compare channels, wishbone registers
//
// Design decisions made here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "timer8_pwm_defs.svh"
// Notes on behaviour
// - waveform select 3 or 7: fast pwm, count bottom to top then restart.
// - fast pwm top is 0xFF for select 3, compare value a for select 7.
// - fast non-inverting: clear on match, set when counter goes to bottom.
// - fast inverting: set on match, clear when counter goes to bottom.
// - fast pwm counter increments to top, then clears on the next tick.
// - fast pwm sets overflow flag each time the counter reaches top.
// - fast pwm compare values double-buffered, loaded at top with overflow flag.
// - fast pwm action 1 toggles output a on each match.
// - fast pwm: compare a at bottom gives spike, at max a constant level.
// - waveform reaches the pin only when the pin direction bit selects output.
// - waveform select 1 or 5: phase correct, top 0xFF or compare value a.
// - phase correct counts up to top, holds top one tick, then counts down.
// - phase correct non-inverting: clear on up match, set on down match.
// - phase correct sets overflow flag each time the counter reaches bottom.
// - phase correct non-inverting: compare at bottom gives constant low, at max constant high.
// - phase correct forces up-match level at bottom when symmetry would break.
// - period 256 or 510 prescaled ticks with top 0xFF; prescale 1,8,32,64,128,256,1024.
// - tick is a clock enable; async mode ticks from the external oscillator.
// - output action 0 disconnects waveform, pin keeps its port value.
// - a software counter write blocks all compare matches in the next tick.
// - output action changes take effect immediately, not buffered.
module timer8_pwm (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  cyc_i,
   input  wire logic                  stb_i,
   input  wire logic                  we_i,
   input  wire logic [7:0]            adr_i,
   input  wire logic [3:0]            sel_i,
   input  wire logic [31:0]           dat_i,
   output      logic [31:0]           dat_o,
   output      logic                  ack_o,
   input  wire logic                  ext_osc_i,
   output      timer8_pwm_pkg::count_t counter_value_o,
   output      logic [1:0]            pin_out_o,
   output      logic [1:0]            pin_oe_o
);
   import timer8_pwm_pkg::*;

   logic [15:0]   ctrl;
   count_t        counter_value;
   dir_e          count_dir;
   count_t        compare_value [2];
   count_t        compare_active [2];
   logic [2:0]    flags;
   logic [1:0]    wave_output;
   logic [1:0]    match;
   logic [1:0]    sym_pending;
   logic          block_match;
   logic [9:0]    div;
   logic          osc_s1;
   logic          osc_s2;
   logic          osc_s3;

   logic [2:0]    waveform_select;
   logic [2:0]    clk_sel;
   logic          async_en;
   logic          fast_mode;
   logic          pc_mode;
   count_t        top;
   logic          at_top;
   logic          at_bot;
   logic          timer_tick;
   logic          base_en;
   logic [9:0]    div_mask;
   logic          req;
   logic          wr;
   logic          count_wr;
   logic          update;
   logic          ovf_set;
   logic [15:0]   next_ctrl;
   count_t        wr_byte;

   assign waveform_select = ctrl[`T8_F_WAVE_SEL +: 3];
   assign clk_sel         = ctrl[`T8_F_CLK_SEL +: 3];
   assign async_en        = ctrl[`T8_F_ASYNC];
   assign fast_mode = (waveform_select == `T8_WAVE_FAST_FF) || (waveform_select == `T8_WAVE_FAST_A);
   assign pc_mode   = (waveform_select == `T8_WAVE_PC_FF) || (waveform_select == `T8_WAVE_PC_A);
   assign top     = waveform_select[2] ? compare_active[0] : `T8_TOP_MAX;
   assign at_top  = (counter_value == top);
   assign at_bot  = (counter_value == `T8_BOTTOM);

   // bus: writes land on the edge where ack is seen high, so a request acts once per ack
   assign req      = cyc_i && stb_i;
   assign wr       = req && we_i && ack_o;
   assign wr_byte  = dat_i[7:0];
   assign count_wr = wr && sel_i[0] && (adr_i == `T8_OFS_COUNT);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= req && !ack_o;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (req && !ack_o) begin
         case (adr_i)
            `T8_OFS_CTRL:  dat_o <= {16'h0000, ctrl};
            `T8_OFS_COUNT: dat_o <= {24'h00_0000, counter_value};
            `T8_OFS_CMP_A: dat_o <= {24'h00_0000, compare_value[0]};
            `T8_OFS_CMP_B: dat_o <= {24'h00_0000, compare_value[1]};
            `T8_OFS_FLAGS: dat_o <= {29'h0000_0000, flags};
            `T8_OFS_STATE: dat_o <= {27'h0000_000, sym_pending, wave_output, count_dir == DIR_DOWN};
            default:       dat_o <= 32'h0000_0000;
         endcase
      end
   end

   always_comb begin
      next_ctrl = ctrl;
      if (sel_i[0]) begin
         next_ctrl[7:0] = dat_i[7:0];
      end
      if (sel_i[1]) begin
         next_ctrl[15:8] = dat_i[15:8];
      end
      next_ctrl = next_ctrl & `T8_CTRL_WMASK;
   end

   // actions are read live from ctrl, no shadow copy
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= `T8_CTRL_RST;
      end else if (wr && (adr_i == `T8_OFS_CTRL)) begin
         ctrl <= next_ctrl;
      end
   end

   // external oscillator synchronised, rising edge becomes the base enable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osc_s1 <= 1'b0;
         osc_s2 <= 1'b0;
         osc_s3 <= 1'b0;
      end else begin
         osc_s1 <= ext_osc_i;
         osc_s2 <= osc_s1;
         osc_s3 <= osc_s2;
      end
   end

   assign base_en = async_en ? (osc_s2 && !osc_s3) : 1'b1;

   always_comb begin
      case (clk_sel)
         3'h1:    div_mask = `T8_DIV_1;
         3'h2:    div_mask = `T8_DIV_8;
         3'h3:    div_mask = `T8_DIV_32;
         3'h4:    div_mask = `T8_DIV_64;
         3'h5:    div_mask = `T8_DIV_128;
         3'h6:    div_mask = `T8_DIV_256;
         default: div_mask = `T8_DIV_1024;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div <= 10'h000;
      end else if (base_en) begin
         div <= div + 10'h001;
      end
   end

   // tick is a one-cycle enable; select 0 stops the timer
   assign timer_tick = base_en && (clk_sel != 3'h0) && ((div & div_mask) == 10'h000);

   // load point of the compare buffers
   assign update = timer_tick && at_top && (fast_mode || (pc_mode && count_dir == DIR_UP));

   assign ovf_set = timer_tick && ((fast_mode && at_top) ||
                                   (pc_mode && at_bot && count_dir == DIR_DOWN) ||
                                   (!fast_mode && !pc_mode && counter_value == `T8_TOP_MAX));

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         counter_value <= `T8_COUNT_RST;
         count_dir     <= DIR_UP;
      end else if (count_wr) begin
         counter_value <= wr_byte;
      end else if (timer_tick) begin
         if (fast_mode) begin
            // wrap on the tick after reaching top
            counter_value <= at_top ? `T8_BOTTOM : counter_value + 8'h01;
         end else if (pc_mode) begin
            // one tick at top, then turn
            if (count_dir == DIR_UP) begin
               if (at_top) begin
                  count_dir     <= DIR_DOWN;
                  counter_value <= at_bot ? counter_value : counter_value - 8'h01;
               end else begin
                  counter_value <= counter_value + 8'h01;
               end
            end else if (at_bot) begin
               count_dir     <= DIR_UP;
               counter_value <= at_top ? counter_value : counter_value + 8'h01;
            end else begin
               counter_value <= counter_value - 8'h01;
            end
         end else begin
            counter_value <= counter_value + 8'h01;
            count_dir     <= DIR_UP;
         end
      end
   end

   // block every match of the tick after a counter write, even while stopped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         block_match <= 1'b0;
      end else if (count_wr) begin
         block_match <= 1'b1;
      end else if (timer_tick) begin
         block_match <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags <= 3'h0;
      end else begin
         // hardware set wins over a write-one clear in the same cycle
         flags <= (flags & ~((wr && sel_i[0] && adr_i == `T8_OFS_FLAGS) ? dat_i[2:0] : 3'h0))
                | {match, ovf_set};
      end
   end

   generate
      for (genvar ch = 0; ch < 2; ch++) begin : g_chan
         logic    eff_up;
         action_t act;
         logic    chan_wr;

         assign act     = ctrl[`T8_F_ACTION + 2*ch +: 2];
         assign chan_wr = wr && sel_i[0] && (adr_i == (ch == 0 ? `T8_OFS_CMP_A : `T8_OFS_CMP_B));
         // match in the tick where counter equals compare
         assign match[ch] = timer_tick && !block_match && (counter_value == compare_active[ch]);
         // a match at top counts as down, at bottom as up
         assign eff_up = at_bot || (count_dir == DIR_UP && !at_top);

         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               compare_value[ch] <= `T8_CMP_RST;
            end else if (chan_wr) begin
               compare_value[ch] <= wr_byte;
            end
         end

         // pwm modes load at top; other modes pass the value straight through
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               compare_active[ch] <= `T8_CMP_RST;
            end else if (update || (!fast_mode && !pc_mode)) begin
               compare_active[ch] <= compare_value[ch];
            end
         end

         // remember a period that would lose symmetry
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               sym_pending[ch] <= 1'b0;
            end else if ((update && compare_active[ch] == `T8_TOP_MAX && compare_value[ch] != `T8_TOP_MAX) ||
                         (count_wr && wr_byte > compare_active[ch])) begin
               sym_pending[ch] <= 1'b1;
            end else if (timer_tick && at_bot && count_dir == DIR_DOWN) begin
               sym_pending[ch] <= 1'b0;
            end
         end

         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               wave_output[ch] <= 1'b0;
            end else if (fast_mode) begin
               // bottom action wins so compare at max stays constant
               if (timer_tick && at_top && act[1]) begin
                  wave_output[ch] <= ~act[0];
               end else if (match[ch] && act[1]) begin
                  wave_output[ch] <= act[0];
               end else if (match[ch] && act == `T8_ACT_TOGGLE && ch == 0) begin
                  wave_output[ch] <= ~wave_output[ch];
               end
            end else if (pc_mode && act[1]) begin
               // up match gives act[0], down match its inverse
               if (match[ch]) begin
                  wave_output[ch] <= eff_up ? act[0] : ~act[0];
               end else if (timer_tick && at_bot && count_dir == DIR_DOWN && sym_pending[ch]) begin
                  // take the up-match level at bottom
                  wave_output[ch] <= act[0];
               end
            end
         end

         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               pin_out_o[ch] <= 1'b0;
               pin_oe_o[ch]  <= 1'b0;
            end else begin
               // action 0 gives the pin back to its port value
               pin_out_o[ch] <= (act != `T8_ACT_OFF) ? wave_output[ch] : ctrl[`T8_F_PORT_VAL + ch];
               pin_oe_o[ch]  <= ctrl[`T8_F_PIN_DIR + ch];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         counter_value_o <= `T8_COUNT_RST;
      end else begin
         counter_value_o <= counter_value;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_fast_wrap;
      timer_tick && fast_mode && at_top && !count_wr |=> counter_value == `T8_BOTTOM;
   endproperty
   a_fast_wrap: assert property (p_fast_wrap) else $error("fast pwm did not wrap after top");

   property p_fast_top;
      fast_mode && !waveform_select[2] |-> top == `T8_TOP_MAX;
   endproperty
   a_fast_top: assert property (p_fast_top) else $error("fast pwm top not 0xFF");

   property p_fast_ovf;
      timer_tick && fast_mode && at_top |=> flags[`T8_F_OVF];
   endproperty
   a_fast_ovf: assert property (p_fast_ovf) else $error("overflow flag missing at top");

   property p_pc_turn;
      timer_tick && pc_mode && count_dir == DIR_UP && at_top && !at_bot && !count_wr
         |=> count_dir == DIR_DOWN && counter_value == $past(counter_value) - 8'h01;
   endproperty
   a_pc_turn: assert property (p_pc_turn) else $error("phase correct did not turn at top");

   property p_pc_ovf;
      timer_tick && pc_mode && at_bot && count_dir == DIR_DOWN |=> flags[`T8_F_OVF];
   endproperty
   a_pc_ovf: assert property (p_pc_ovf) else $error("overflow flag missing at bottom");

   property p_dbuf;
      (fast_mode || pc_mode) && !update |=> compare_active[0] == $past(compare_active[0]);
   endproperty
   a_dbuf: assert property (p_dbuf) else $error("compare value changed outside top");

   property p_block;
      count_wr ##1 timer_tick |-> match == 2'b00;
   endproperty
   a_block: assert property (p_block) else $error("match after counter write");

   property p_oe;
      ##1 1'b1 |-> pin_oe_o[0] == $past(ctrl[`T8_F_PIN_DIR]);
   endproperty
   a_oe: assert property (p_oe) else $error("pin enable does not follow direction");

   property p_disc;
      ctrl[`T8_F_ACTION +: 2] == `T8_ACT_OFF |=> pin_out_o[0] == $past(ctrl[`T8_F_PORT_VAL]);
   endproperty
   a_disc: assert property (p_disc) else $error("pin not on port value with action off");

   property p_fast_set;
      timer_tick && fast_mode && at_top && ctrl[`T8_F_ACTION +: 2] == `T8_ACT_NONINV |=> wave_output[0];
   endproperty
   a_fast_set: assert property (p_fast_set) else $error("non-inverting output not set at bottom");

   property p_pc_low;
      pc_mode && ctrl[`T8_F_ACTION +: 2] == `T8_ACT_NONINV && compare_active[0] == `T8_BOTTOM
         && !wave_output[0] |=> !wave_output[0];
   endproperty
   a_pc_low: assert property (p_pc_low) else $error("phase correct output left low at bottom compare");

endmodule : timer8_pwm
